// ==== fsim_regs.vh ====
`ifndef FSIM_REGS_VH
`define FSIM_REGS_VH

// Register byte offsets on the Wishbone slave.
`define FSIM_OFF_CTRL       8'h00
`define FSIM_OFF_RST_SEL    8'h04
`define FSIM_OFF_STATUS     8'h08
`define FSIM_OFF_NOTE       8'h0C
`define FSIM_OFF_IRQ_STAT   8'h10
`define FSIM_OFF_IRQ_CLR    8'h14
`define FSIM_OFF_IRQ_EN     8'h18

// Control register fields.
`define FSIM_CTRL_FAN_LSB   0
`define FSIM_CTRL_DCL_LSB   2
`define FSIM_MODE_W         2

// Notification modes and their reset value.
`define FSIM_MODE_NONE      2'h0
`define FSIM_MODE_NOTE      2'h1
`define FSIM_MODE_WARN      2'h2
`define FSIM_MODE_RESET     2'h1

// Reset selector values.
`define FSIM_RSEL_NONE      2'h0
`define FSIM_RSEL_DCL       2'h1
`define FSIM_RSEL_FAN       2'h2

// Status register fields.
`define FSIM_ST_FAN_PCT_LSB 0
`define FSIM_ST_DCL_PCT_LSB 8
`define FSIM_ST_FAN_EXP     16
`define FSIM_ST_DCL_EXP     17

// Interrupt bits, shared by status, clear and enable.
`define FSIM_IRQ_FAN        0
`define FSIM_IRQ_DCL        1
`define FSIM_IRQ_W          2

// Maintenance note codes.
`define FSIM_NOTE_W         16
`define FSIM_NOTE_NONE      16'h0000
`define FSIM_NOTE_DCL       16'h0001
`define FSIM_NOTE_FAN       16'h0002

// Percentage range.
`define FSIM_PCT_W          7
`define FSIM_PCT_FULL       7'h64

// Capacitor temperature aging: weight doubles every step above the base, up to the maximum shift.
`define FSIM_TEMP_BASE      8'h28
`define FSIM_TEMP_STEP      8'h0A
`define FSIM_TEMP_MAX_SHIFT 4'h8

`endif

// ==== fsim_life_counter.v ====
`timescale 1ns/1ns
`include "fsim_regs.vh"

// Remaining-life counter: accumulates wear and steps a percentage down to zero.
module fsim_life_counter #(
	parameter INC_W = 16,
	parameter ACC_W = 40,
	parameter [ACC_W-1:0] STEP = 40'h0100000000
)(
	input  wire                   clk,       // System clock.
	input  wire                   rst_n,     // Asynchronous reset, active low.
	input  wire                   restore,   // One-cycle pulse, back to full.
	input  wire [INC_W-1:0]       wear_inc,  // Wear units added this cycle.
	output reg  [`FSIM_PCT_W-1:0] pct_r,     // Remaining life in percent.
	output reg                    expired_r  // High while the percentage is zero.
);

	reg  [ACC_W-1:0] acc_r;
	wire [ACC_W:0]   acc_sum;

	assign acc_sum = {1'b0, acc_r} + {{(ACC_W+1-INC_W){1'b0}}, wear_inc};

	// Restore wins over aging; at zero the count holds so it can never wrap.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_r     <= {ACC_W{1'b0}};
			pct_r     <= `FSIM_PCT_FULL;
			expired_r <= 1'b0;
		end
		else if (restore)
		begin
			acc_r     <= {ACC_W{1'b0}};
			pct_r     <= `FSIM_PCT_FULL;
			expired_r <= 1'b0;
		end
		else if (pct_r != {`FSIM_PCT_W{1'b0}})
		begin
			if (acc_sum >= {1'b0, STEP})
			begin
				acc_r     <= acc_sum[ACC_W-1:0] - STEP; // RULE13
				pct_r     <= pct_r - 7'h01;
				expired_r <= (pct_r == 7'h01);
			end
			else
			begin
				acc_r <= acc_sum[ACC_W-1:0];
			end
		end
		else
		begin
			expired_r <= 1'b1; // RULE13
		end
	end

endmodule // fsim_life_counter

// ==== fsim_top.v ====
`timescale 1ns/1ns
`include "fsim_regs.vh"

// Operation
// RULE1: fan life from speed and running time
// RULE2: mode 0 monitors only, no note, warning
// RULE3: mode 1 shows fan code on expiry
// RULE4: mode 2 adds warning, flag, panel indication
// RULE5: note shows no-service code when none due
// RULE6: warning offered internally and on digital output
// RULE7: operator selects mode 2 for warnings
// RULE8: remaining life in percent, zero means service
// RULE9: selector 0 leaves both counters alone
// RULE10: selector 1 restores DC-link to 100
// RULE11: selector 2 restores fan to 100
// RULE12: DC-link aging faster with capacitor temperature
// RULE13: percentage falls, saturates at zero, holds
module fsim_top #(
	parameter [39:0] FAN_STEP = 40'h0100000000,
	parameter [39:0] DCL_STEP = 40'h0100000000
)(
	input  wire        clk,             // System clock, 100 MHz.
	input  wire        rst_n,           // Asynchronous reset, active low.
	input  wire        wb_cyc_i,        // Wishbone cycle.
	input  wire        wb_stb_i,        // Wishbone strobe.
	input  wire        wb_we_i,         // Wishbone write enable.
	input  wire [7:0]  wb_adr_i,        // Wishbone byte address.
	input  wire [3:0]  wb_sel_i,        // Wishbone byte selects.
	input  wire [31:0] wb_dat_i,        // Wishbone write data.
	output reg  [31:0] wb_dat_o,        // Wishbone read data.
	output reg         wb_ack_o,        // Wishbone acknowledge.
	input  wire [15:0] fan_speed_i,     // Fan speed from the tacho logic, same clock.
	input  wire [7:0]  cap_temp_i,      // Capacitor temperature, same clock.
	input  wire        drive_run_i,     // Inverter in operation, from a pin.
	output reg  [15:0] maint_note_o,    // Maintenance note code.
	output reg         fan_warn_link_o, // Fan warning for internal linking.
	output reg         fan_warn_dout_o, // Fan warning for a digital output.
	output reg         dcl_warn_o,      // DC-link warning.
	output reg         panel_warn_o,    // Warning shown on the operator panel.
	output reg         irq_o            // Level interrupt.
);

	reg  [`FSIM_MODE_W-1:0] fan_mode_r;
	reg  [`FSIM_MODE_W-1:0] dcl_mode_r;
	reg  [`FSIM_IRQ_W-1:0]  irq_stat_r;
	reg  [`FSIM_IRQ_W-1:0]  irq_en_r;
	reg  [`FSIM_IRQ_W-1:0]  irq_stat_nxt;
	reg                     run_meta_r;
	reg                     run_sync_r;
	reg                     fan_exp_d_r;
	reg                     dcl_exp_d_r;
	reg                     fan_restore_r;
	reg                     dcl_restore_r;
	reg  [31:0]             rd_nxt;
	reg  [15:0]             note_nxt;
	wire                    wr_go;
	wire                    req;
	wire [15:0]             fan_inc;
	wire [15:0]             dcl_inc;
	wire [`FSIM_PCT_W-1:0]  fan_pct;
	wire [`FSIM_PCT_W-1:0]  dcl_pct;
	wire                    fan_exp;
	wire                    dcl_exp;
	wire                    fan_note;
	wire                    dcl_note;
	wire                    fan_warn;
	wire                    dcl_warn;
	wire [`FSIM_IRQ_W-1:0]  exp_event;
	wire [`FSIM_IRQ_W-1:0]  clr_bits;

	// Aging weight: doubles for each temperature step above the base, capped.
	function [15:0] temp_weight;
		input [7:0] temp;
		reg   [7:0] over;
		reg   [7:0] steps;
		reg   [3:0] shift;
		begin
			over  = 8'h00;
			shift = 4'h0;
			if (temp > `FSIM_TEMP_BASE)
				over = temp - `FSIM_TEMP_BASE;
			steps = over / `FSIM_TEMP_STEP;
			// The cap keeps the weight inside sixteen bits at any temperature.
			if (steps > {4'h0, `FSIM_TEMP_MAX_SHIFT})
				shift = `FSIM_TEMP_MAX_SHIFT;
			else
				shift = steps[3:0];
			temp_weight = 16'h0001 << shift;
		end
	endfunction

	// Mode test, used by the note decisions; warnings compare against mode 2 directly.
	function mode_at_least;
		input [`FSIM_MODE_W-1:0] mode;
		input [`FSIM_MODE_W-1:0] level;
		begin
			mode_at_least = (mode >= level) && (mode <= `FSIM_MODE_WARN);
		end
	endfunction

	// The run pin is asynchronous, so it passes two flip-flops first.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_meta_r <= 1'b0;
			run_sync_r <= 1'b0;
		end
		else
		begin
			run_meta_r <= drive_run_i;
			run_sync_r <= run_meta_r;
		end
	end

	// Fan wear grows with speed each cycle; a stopped fan adds no running time.
	assign fan_inc = fan_speed_i; // RULE1

	// Capacitors age only while the drive runs; off-time aging is not seen here.
	assign dcl_inc = run_sync_r ? temp_weight(cap_temp_i) : 16'h0000; // RULE12

	// Fan counter: wear is speed summed over running time.
	fsim_life_counter #(
		.INC_W (16),
		.ACC_W (40),
		.STEP  (FAN_STEP)
	) u_fan_life (
		.clk       (clk),
		.rst_n     (rst_n),
		.restore   (fan_restore_r),
		.wear_inc  (fan_inc),
		.pct_r     (fan_pct),
		.expired_r (fan_exp)
	);

	// DC-link counter: its own step lets the two intervals be scaled apart.
	fsim_life_counter #(
		.INC_W (16),
		.ACC_W (40),
		.STEP  (DCL_STEP)
	) u_dcl_life (
		.clk       (clk),
		.rst_n     (rst_n),
		.restore   (dcl_restore_r),
		.wear_inc  (dcl_inc),
		.pct_r     (dcl_pct),
		.expired_r (dcl_exp)
	);

	// Mode 0 keeps counting but suppresses every note and warning.
	assign fan_note = fan_exp && mode_at_least(fan_mode_r, `FSIM_MODE_NOTE); // RULE2 RULE3
	assign dcl_note = dcl_exp && mode_at_least(dcl_mode_r, `FSIM_MODE_NOTE);
	assign fan_warn = fan_exp && (fan_mode_r == `FSIM_MODE_WARN); // RULE4 RULE7
	assign dcl_warn = dcl_exp && (dcl_mode_r == `FSIM_MODE_WARN);

	// One note code at a time; the fan wins when both are due.
	always @*
	begin
		note_nxt = `FSIM_NOTE_NONE; // RULE5
		if (fan_note)
			note_nxt = `FSIM_NOTE_FAN; // RULE3
		else if (dcl_note)
			note_nxt = `FSIM_NOTE_DCL;
	end

	// Outputs are registered so the pins never glitch on mode writes.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			maint_note_o    <= `FSIM_NOTE_NONE;
			fan_warn_link_o <= 1'b0;
			fan_warn_dout_o <= 1'b0;
			dcl_warn_o      <= 1'b0;
			panel_warn_o    <= 1'b0;
			irq_o           <= 1'b0;
		end
		else
		begin
			maint_note_o    <= note_nxt;
			fan_warn_link_o <= fan_warn; // RULE6
			fan_warn_dout_o <= fan_warn; // RULE6
			dcl_warn_o      <= dcl_warn;
			panel_warn_o    <= fan_warn | dcl_warn; // RULE4
			// The next status is used so the line rises with the status bit.
			irq_o           <= |(irq_stat_nxt & irq_en_r);
		end
	end

	// Expiry events only count where the mode asks for a note or warning.
	assign exp_event[`FSIM_IRQ_FAN] = fan_note && !fan_exp_d_r;
	assign exp_event[`FSIM_IRQ_DCL] = dcl_note && !dcl_exp_d_r;

	// Bus handshake: a request is taken once, acked one cycle later.
	assign req   = wb_cyc_i && wb_stb_i;
	assign wr_go = req && wb_we_i && wb_ack_o;

	// Clear bits live in byte 0, so its select gates the clear strobe.
	assign clr_bits = (wr_go && wb_sel_i[0] && (wb_adr_i == `FSIM_OFF_IRQ_CLR)) ?
		wb_dat_i[`FSIM_IRQ_W-1:0] : {`FSIM_IRQ_W{1'b0}};

	// A new event in the clearing cycle survives: set beats clear.
	always @*
	begin
		irq_stat_nxt = (irq_stat_r & ~clr_bits) | exp_event;
	end

	// Sticky status and the delayed note flags that form the expiry edges.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_stat_r  <= {`FSIM_IRQ_W{1'b0}};
			fan_exp_d_r <= 1'b0;
			dcl_exp_d_r <= 1'b0;
		end
		else
		begin
			irq_stat_r  <= irq_stat_nxt;
			fan_exp_d_r <= fan_note;
			dcl_exp_d_r <= dcl_note;
		end
	end

	// Read multiplexer; unmapped and write-only offsets read as zero.
	always @*
	begin
		rd_nxt = 32'h00000000;
		if (wb_adr_i == `FSIM_OFF_CTRL)
		begin
			rd_nxt[`FSIM_CTRL_FAN_LSB+:`FSIM_MODE_W] = fan_mode_r;
			rd_nxt[`FSIM_CTRL_DCL_LSB+:`FSIM_MODE_W] = dcl_mode_r;
		end
		else if (wb_adr_i == `FSIM_OFF_STATUS)
		begin
			// Expiry flags sit beside the percentages so one read gives both.
			rd_nxt[`FSIM_ST_FAN_PCT_LSB+:`FSIM_PCT_W] = fan_pct; // RULE8
			rd_nxt[`FSIM_ST_DCL_PCT_LSB+:`FSIM_PCT_W] = dcl_pct;
			rd_nxt[`FSIM_ST_FAN_EXP]                  = fan_exp;
			rd_nxt[`FSIM_ST_DCL_EXP]                  = dcl_exp;
		end
		else if (wb_adr_i == `FSIM_OFF_NOTE)
			rd_nxt[15:0] = maint_note_o;
		else if (wb_adr_i == `FSIM_OFF_IRQ_STAT)
			rd_nxt[`FSIM_IRQ_W-1:0] = irq_stat_r;
		else if (wb_adr_i == `FSIM_OFF_IRQ_EN)
			rd_nxt[`FSIM_IRQ_W-1:0] = irq_en_r;
	end

	// Ack drops after one cycle even if strobe stays high, so no double take.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= req && !wb_ack_o;
			if (req && !wb_ack_o && !wb_we_i)
				wb_dat_o <= rd_nxt;
			else
				wb_dat_o <= 32'h00000000;
		end
	end

	// Register writes land on the edge where the master sees ack.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fan_mode_r    <= `FSIM_MODE_RESET;
			dcl_mode_r    <= `FSIM_MODE_RESET;
			irq_en_r      <= {`FSIM_IRQ_W{1'b0}};
			fan_restore_r <= 1'b0;
			dcl_restore_r <= 1'b0;
		end
		else
		begin
			fan_restore_r <= 1'b0; // RULE9
			dcl_restore_r <= 1'b0; // RULE9
			// Every field sits in byte 0, so a write without sel[0] is ignored.
			if (wr_go && wb_sel_i[0])
			begin
				if (wb_adr_i == `FSIM_OFF_CTRL)
				begin
					fan_mode_r <= wb_dat_i[`FSIM_CTRL_FAN_LSB+:`FSIM_MODE_W];
					dcl_mode_r <= wb_dat_i[`FSIM_CTRL_DCL_LSB+:`FSIM_MODE_W];
				end
				else if (wb_adr_i == `FSIM_OFF_RST_SEL)
				begin
					// Selector acts once per write and is not stored, so it reads zero.
					dcl_restore_r <= (wb_dat_i[31:0] == {30'h0, `FSIM_RSEL_DCL}); // RULE10
					fan_restore_r <= (wb_dat_i[31:0] == {30'h0, `FSIM_RSEL_FAN}); // RULE11
				end
				else if (wb_adr_i == `FSIM_OFF_IRQ_EN)
					irq_en_r <= wb_dat_i[`FSIM_IRQ_W-1:0];
			end
		end
	end

endmodule // fsim_top

// ==== fsim_top_properties.sv ====
`timescale 1ns/1ns
`include "fsim_regs.vh"

// Bus timing and output coherence seen from the pins.
module fsim_top_properties (
	input wire        clk,             // Clock.
	input wire        rst_n,           // Reset.
	input wire        wb_cyc_i,        // Cycle.
	input wire        wb_stb_i,        // Strobe.
	input wire        wb_we_i,         // Write.
	input wire [7:0]  wb_adr_i,        // Address.
	input wire [31:0] wb_dat_o,        // Read data.
	input wire        wb_ack_o,        // Ack.
	input wire [15:0] maint_note_o,    // Note.
	input wire        fan_warn_link_o, // Fan link.
	input wire        fan_warn_dout_o, // Fan out.
	input wire        dcl_warn_o       // DC-link.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire rd = wb_ack_o && !wb_we_i;

	// A taken request is answered after exactly one wait state.
	a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack long");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack unasked");
	a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data idle");
	a_wo_read_zero: assert property (rd && (wb_adr_i == `FSIM_OFF_RST_SEL || wb_adr_i == `FSIM_OFF_IRQ_CLR)
		|-> wb_dat_o == 32'h0) else $error("wo read");
	a_status_coherent: assert property (rd && wb_adr_i == `FSIM_OFF_STATUS |-> wb_dat_o[6:0] <= 7'h64
		&& wb_dat_o[16] == (wb_dat_o[6:0] == 7'h0) && wb_dat_o[17] == (wb_dat_o[14:8] == 7'h0))
		else $error("status");
	a_warn_pins_same: assert property (fan_warn_link_o == fan_warn_dout_o)
		else $error("warn pins");
	a_fan_warn_note: assert property (fan_warn_link_o |-> maint_note_o == `FSIM_NOTE_FAN)
		else $error("warn note");
	a_note_legal: assert property (maint_note_o inside {16'h0000, 16'h0001, 16'h0002})
		else $error("note code");
	a_dcl_warn_note: assert property (dcl_warn_o |-> maint_note_o != `FSIM_NOTE_NONE)
		else $error("dcl note");
	c_fan_warn: cover property ($rose(fan_warn_link_o));
	c_dcl_warn: cover property ($rose(dcl_warn_o));
	c_fan_note: cover property (maint_note_o == `FSIM_NOTE_FAN);
endmodule // fsim_top_properties

bind fsim_top fsim_top_properties u_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .maint_note_o(maint_note_o), .fan_warn_link_o(fan_warn_link_o),
	.fan_warn_dout_o(fan_warn_dout_o), .dcl_warn_o(dcl_warn_o));

// ==== test_fsim_top.sv ====
`timescale 1ns/1ns
`include "fsim_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t %h %h", $time, a, e); end end

module test_fsim_top;
	localparam [7:0] CT = `FSIM_OFF_CTRL, RS = `FSIM_OFF_RST_SEL, ST = `FSIM_OFF_STATUS;
	localparam [7:0] IS = `FSIM_OFF_IRQ_STAT, IC = `FSIM_OFF_IRQ_CLR, IE = `FSIM_OFF_IRQ_EN;
	reg         clk, rst_n, cyc, stb, we, run;
	reg  [7:0]  adr, temp;
	reg  [3:0]  sel;
	reg  [31:0] wdat, q, r;
	reg  [15:0] speed;
	wire [31:0] rdat;
	wire [15:0] note;
	wire        ack, wl, wd, dw, pw, irq;
	integer     fail_count, checks, cycles, i;

	// Short steps keep the run brief: 10 cycles per fan percent at speed 100.
	fsim_top #(.FAN_STEP(40'h00000003E8), .DCL_STEP(40'h0000000004)) dut (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .fan_speed_i(speed), .cap_temp_i(temp), .drive_run_i(run),
		.maint_note_o(note), .fan_warn_link_o(wl), .fan_warn_dout_o(wd), .dcl_warn_o(dw),
		.panel_warn_o(pw), .irq_o(irq));

	// Free-running clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cuts a hang short well past the expected length of the run.
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			end_sim;
		end
	end

	// Status word expected from the two percentages.
	function [31:0] st_exp(input [6:0] f, input [6:0] d);
		st_exp = {14'h0, d == 7'h0, f == 7'h0, 1'b0, d, 1'b0, f};
	endfunction

	// One classic cycle; read data is taken at the rising edge where ack is seen high.
	task wb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hF};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
	end
	endtask

	// Lets register outputs follow a change.
	task settle;
		repeat (3) @(negedge clk);
	endtask

	task end_sim;
	begin
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask

	initial
	begin
		{rst_n, cyc, stb, we, run, adr, sel, wdat, speed} = 0;
		temp = 8'h28;
		{fail_count, checks, cycles} = 0;
		r = $urandom(32'h58674e3a);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK({note, wl, wd, dw, pw, irq}, 21'h0)
		wb(0, CT, 0);
		`CHK(q, 32'h5)
		wb(1, 8'h1C, 32'hFFFFFFFF);
		wb(0, 8'h1C, 0);
		`CHK(q, 32'h0)
		wb(0, IE, 0);
		`CHK(q, 32'h0)
		// Random modes read back, and selector values other than 1 or 2 change nothing.
		for (i = 0; i < 4; i++)
		begin
			r = $urandom;
			wb(1, CT, r);
			wb(0, CT, 0);
			`CHK(q, {28'h0, r[3:0]})
			wb(1, RS, r | 32'h4);
		end
		wb(1, CT, 32'h5);
		wb(1, IE, 32'h3);
		run <= 1'b1;
		repeat (450) @(posedge clk);
		wb(0, ST, 0);
		`CHK(q, st_exp(7'h64, 7'h0))
		`CHK({note, dw, irq}, {`FSIM_NOTE_DCL, 2'h1})
		wb(0, IS, 0);
		`CHK(q, 32'h2)
		wb(1, IE, 32'h0);
		settle;
		`CHK(irq, 1'b0)
		wb(1, IE, 32'h2);
		settle;
		`CHK(irq, 1'b1)
		wb(1, IC, 32'h2);
		settle;
		`CHK(irq, 1'b0)
		wb(0, IS, 0);
		`CHK(q, 32'h0)
		wb(1, CT, 32'h9);
		run <= 1'b0;
		settle;
		`CHK({dw, pw}, 2'h3)
		wb(1, RS, 32'h1);
		settle;
		wb(0, ST, 0);
		`CHK(q, st_exp(7'h64, 7'h64))
		`CHK({note, dw}, 17'h0)
		// At 60 degrees each percent takes one cycle instead of four.
		temp <= 8'h3C;
		run <= 1'b1;
		repeat (150) @(posedge clk);
		run <= 1'b0;
		wb(0, ST, 0);
		`CHK(q, st_exp(7'h64, 7'h0))
		wb(1, RS, 32'h1);
		wb(1, CT, 32'h0);
		wb(1, IE, 32'h1);
		speed <= 16'h0064;
		repeat (500) @(posedge clk);
		wb(0, ST, 0);
		r = q;
		`CHK(q[6:0] > 7'h0 && q[6:0] < 7'h64, 1'b1)
		repeat (20) @(posedge clk);
		wb(0, ST, 0);
		`CHK(q[6:0] < r[6:0], 1'b1)
		repeat (700) @(posedge clk);
		wb(0, ST, 0);
		`CHK(q, st_exp(7'h0, 7'h64))
		`CHK({note, wl, irq}, 18'h0)
		wb(1, CT, 32'h1);
		settle;
		`CHK({note, wl, irq}, {`FSIM_NOTE_FAN, 2'h1})
		wb(1, CT, 32'h2);
		settle;
		`CHK({wl, wd, pw}, 3'h7)
		wb(1, RS, 32'h0);
		wb(0, ST, 0);
		`CHK(q, st_exp(7'h0, 7'h64))
		speed <= 16'h0000;
		wb(1, RS, 32'h2);
		settle;
		wb(0, ST, 0);
		`CHK(q, st_exp(7'h64, 7'h64))
		`CHK({note, wl}, 17'h0)
		end_sim;
	end
endmodule // test_fsim_top
